//--- dv/plc_ctrl_sva.sv
/*
 * Pin-level checks for the synthesizer control block.
 * Assumes it is bound to plc_ctrl and sees only that module's ports.
 */
`default_nettype none

module plc_ctrl_sva
(
	// Clock, reset, serial select and read-data enable
	input wire logic                     clk_sys,
	input wire logic                     sys_rst,
	input wire logic                     port_sel_n,
	input wire logic                     port_sdo_oe,
	// Loop lock reports
	input wire logic                     first_loop_locked,
	input wire logic                     second_loop_locked,
	// Controls and outputs
	input wire logic                     first_loop_run,
	input wire logic                     second_loop_run,
	input wire logic [plc_pkg::FIELD_LSB+2:0] loop_multiplier,
	input wire logic                     frame_pulse_out_enable,
	input wire logic                     synth_out_a_gate,
	input wire logic                     synth_out_b_gate,
	input wire logic                     lock_indicator_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_b_gate; synth_out_b_gate |-> second_loop_run; endproperty
	a_b_gate: assert property (p_b_gate)
		else $error("second output gate open with its loop off");
	property p_a_gate; synth_out_a_gate |-> first_loop_run; endproperty
	a_a_gate: assert property (p_a_gate)
		else $error("first output gate open with its loop off");
	// Reset itself is the cause here, so this one is never disabled.
	property p_rst;
		disable iff (1'b0) sys_rst |=> !second_loop_run && !synth_out_b_gate
			&& !lock_indicator_out && !port_sdo_oe && !frame_pulse_out_enable;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not cleared by reset");
	property p_lock_cause;
		lock_indicator_out |-> $past(first_loop_locked, 3) || $past(second_loop_locked, 3);
	endproperty
	a_lock_cause: assert property (p_lock_cause)
		else $error("lock indicator high with no loop locked");
	property p_lock_steady;
		(port_sel_n && $stable(first_loop_locked) && $stable(second_loop_locked))[*8]
			|-> $stable(lock_indicator_out);
	endproperty
	a_lock_steady: assert property (p_lock_steady)
		else $error("lock indicator moved with steady inputs");
	property p_oe_idle; port_sel_n[*6] |-> !port_sdo_oe; endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("read data driven outside a frame");
	property p_oe_frame; port_sdo_oe |-> !$past(port_sel_n, 3); endproperty
	a_oe_frame: assert property (p_oe_frame)
		else $error("read data enable not tied to select");
	property p_idle_stable;
		port_sel_n[*8] |-> $stable(loop_multiplier) && $stable(second_loop_run);
	endproperty
	a_idle_stable: assert property (p_idle_stable)
		else $error("control changed without a frame");

	c_write: cover property ($rose(second_loop_run));
	c_lock: cover property ($rose(lock_indicator_out));
	c_read: cover property ($rose(port_sdo_oe));
endmodule

`default_nettype wire

//--- dv/plc_ctrl_tb.sv
/*
 * Self-checking bench for plc_ctrl: serial frames and lock levels.
 * Assumes the hand-over latencies; sclk phases are kept long on purpose.
 */
`default_nettype none

module plc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import plc_pkg::*;

	// ****************************************************************
	// Signals and tasks
	// ****************************************************************
	logic       clk_sys = 1'b0, sys_rst = 1'b1, port_sel_n = 1'b1, port_sclk = 1'b1;
	logic       port_sdi = 1'b0, first_loop_locked = 1'b0, second_loop_locked = 1'b0;
	logic       port_sdo, port_sdo_oe, first_loop_run, second_loop_run;
	logic       frame_pulse_out_enable, synth_out_a_gate, synth_out_b_gate, lock_indicator_out;
	logic [3:0] mode_field, loop_multiplier;
	logic [4:0] rd;
	int         num_errors = 0, samples_checked = 0;

	plc_ctrl i_dut (.clk_sys, .sys_rst, .port_sel_n, .port_sclk, .port_sdi, .port_sdo,
		.port_sdo_oe, .first_loop_locked, .second_loop_locked, .first_loop_run,
		.second_loop_run, .mode_field, .loop_multiplier, .frame_pulse_out_enable,
		.synth_out_a_gate, .synth_out_b_gate, .lock_indicator_out);

	initial
		forever #50 clk_sys = ~clk_sys;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [4:0] outs();
		return {second_loop_run, synth_out_b_gate, frame_pulse_out_enable,
			synth_out_a_gate, lock_indicator_out};
	endfunction

	// Each sclk phase spans several clk_sys cycles so the pin synchroniser sees every edge.
	task automatic xfer(input logic r, input logic [3:0] a, input logic [4:0] d,
		input int n, output logic [4:0] q);
		logic [9:0] f;
		f = {r, a, d};
		q = 5'h00;
		port_sel_n <= 1'b0;
		cyc(3);
		for (int i = 0; i < n; i++)
		begin
			port_sclk <= 1'b0;
			port_sdi <= f[9-i];
			cyc(6);
			if (i > 4)
			begin
				q = {q[3:0], port_sdo};
				if (r)
					chk("sdo enable", 5'h01, {4'h0, port_sdo_oe});
			end
			port_sclk <= 1'b1;
			cyc(4);
		end
		cyc(2);
		port_sel_n <= 1'b1;
		cyc(8);
		chk("sdo release", 5'h00, {4'h0, port_sdo_oe});
	endtask

	task automatic wr(input logic [3:0] a, input logic [4:0] d);
		xfer(1'b0, a, d, 10, rd);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [4:0] exp);
		xfer(1'b1, a, 5'h00, 10, rd);
		chk("readback", exp, rd);
	endtask

	// Steps through all four lock combinations under one selection.
	task automatic lk(input logic [1:0] s, input logic b_on);
		logic [4:0] ex;
		for (int k = 0; k < 4; k++)
		begin
			first_loop_locked <= k[0];
			second_loop_locked <= k[1];
			cyc(6);
			case (s)
				2'h3: ex = {4'h0, k[0] & (k[1] | !b_on)};
				2'h2: ex = {4'h0, k[0]};
				2'h1: ex = {4'h0, k[1]};
				default: ex = 5'h00;
			endcase
			chk("lock", ex, {4'h0, lock_indicator_out});
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		cyc(5);
		sys_rst <= 1'b0;
		cyc(3);
		chk("outs", 5'h00, outs());
		chk("first run", 5'h00, {4'h0, first_loop_run});
		chk("mode", 5'h00, {1'b0, mode_field});
		rdchk(ADDR_LOOP_B, RST_REG);
		rdchk(ADDR_OUT_EN, RST_REG);
		wr(ADDR_LOOP_B, 5'h01);
		wr(ADDR_OUT_EN, 5'h1F);
		chk("outs", 5'h1C, outs());
		chk("multiplier", 5'h00, {1'b0, loop_multiplier});
		rdchk(ADDR_OUT_EN, 5'h1F);
		wr(ADDR_TUNE_A, 5'h1F);
		wr(ADDR_TUNE_B, 5'h1F);
		wr(4'h7, 5'h1F);
		chk("outs", 5'h1C, outs());
		rdchk(ADDR_TUNE_B, 5'h1F);
		rdchk(4'h7, 5'h00);
		xfer(1'b0, ADDR_OUT_EN, 5'h00, 6, rd);
		rdchk(ADDR_OUT_EN, 5'h1F);
		wr(ADDR_LOOP_B, 5'h1F);
		chk("multiplier", 5'h0F, {1'b0, loop_multiplier});
		wr(ADDR_LOOP_B, 5'h1E);
		chk("outs", 5'h04, outs());
		wr(ADDR_LOOP_A, 5'h11);
		chk("outs", 5'h06, outs());
		chk("first run", 5'h01, {4'h0, first_loop_run});
		chk("mode", 5'h08, {1'b0, mode_field});
		rdchk(ADDR_LOOP_A, 5'h11);
		lk(2'h3, 1'b0);
		wr(ADDR_LOOP_B, 5'h01);
		wr(ADDR_OUT_EN, 5'h08);
		chk("outs", 5'h12, outs());
		for (int s = 0; s < 4; s++)
		begin
			wr(ADDR_OUT_EN, {3'b111, s[1:0]});
			lk(s[1:0], 1'b1);
		end
		summarize();
	end

	initial
	begin
		cyc(20000);
		num_errors++;
		summarize();
	end
endmodule

bind plc_ctrl plc_ctrl_sva i_sva (.clk_sys, .sys_rst, .port_sel_n, .port_sdo_oe,
	.first_loop_locked, .second_loop_locked, .first_loop_run, .second_loop_run,
	.loop_multiplier, .frame_pulse_out_enable, .synth_out_a_gate, .synth_out_b_gate,
	.lock_indicator_out);

`default_nettype wire

//--- rtl/plc_ctrl.sv
/*
 * Control logic of a dual-loop clock synthesizer: serial command port,
 * command registers, output gating and the selectable lock indicator.
 * Assumes the analog loops report lock as plain levels and the serial
 * port clock runs well below a quarter of clk_sys.
 */
// Operation
// - second output runs only while second-loop enable set
// - tuning registers never steer this logic
// - output-enable register fields at D4 through D0
// - combined mode: high only when enabled loops locked
// - first-only mode follows first loop lock
// - second-only mode follows second loop lock
// - forced-low mode keeps indicator low
`default_nettype none

module plc_ctrl
(
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	// Serial command port pins
	input  wire logic                        port_sel_n,
	input  wire logic                        port_sclk,
	input  wire logic                        port_sdi,
	output logic                             port_sdo,
	output logic                             port_sdo_oe,
	// Lock reports from the analog loops
	input  wire logic                        first_loop_locked,
	input  wire logic                        second_loop_locked,
	// Controls toward the analog loops and output drivers
	output logic                             first_loop_run,
	output logic                             second_loop_run,
	output logic [plc_pkg::FIELD_LSB+2:0]    mode_field,
	output logic [plc_pkg::FIELD_LSB+2:0]    loop_multiplier,
	output logic                             frame_pulse_out_enable,
	output logic                             synth_out_a_gate,
	output logic                             synth_out_b_gate,
	output logic                             lock_indicator_out
);

	import plc_pkg::*;

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [4:0] pins_s;
	logic       sel_act_s;
	logic       sclk_low_s;
	logic       sel_n_s;
	logic       sclk_s;
	logic       sdi_s;
	logic       lock_a_s;
	logic       lock_b_s;
	logic       sclk_q;
	logic       sclk_rise;
	logic       sclk_fall;

	// Select and sclk idle high, so they cross inverted: the synchroniser clears to
	// their idle level and no false frame start or sclk edge follows reset.
	plc_sync #(
		.WIDTH (5)
	) u_sync (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.async_in ({~port_sel_n, ~port_sclk, port_sdi, first_loop_locked, second_loop_locked}),
		.sync_out (pins_s)
	);

	assign {sel_act_s, sclk_low_s, sdi_s, lock_a_s, lock_b_s} = pins_s;
	assign sel_n_s   = ~sel_act_s;
	assign sclk_s    = ~sclk_low_s;
	assign sclk_rise = sclk_s & ~sclk_q;
	assign sclk_fall = ~sclk_s & sclk_q;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			sclk_q <= 1'b1;
		else
			sclk_q <= sclk_s;
	end

	// ****************************************************************
	// Serial frame engine
	// ****************************************************************
	plc_state_t          state;
	logic [3:0]          bit_cnt;
	logic [FRAME_BITS-2:0] shift_in;
	logic [REG_W-1:0]    rd_shift;
	logic                rd_active;
	logic                wr_strobe;
	logic [ADDR_W-1:0]   wr_addr;
	logic [REG_W-1:0]    wr_data;
	logic [ADDR_W-1:0]   hdr_addr;
	logic [REG_W-1:0]    reg_loop_a;
	logic [REG_W-1:0]    reg_loop_b;
	logic [REG_W-1:0]    reg_tune_a;
	logic [REG_W-1:0]    reg_tune_b;
	logic [REG_W-1:0]    reg_out_en;
	logic [REG_W-1:0]    rd_value;

	assign hdr_addr = {shift_in[2:0], sdi_s};

	// Unmapped addresses read as zero.
	always_comb
	begin
		unique case (hdr_addr)
			ADDR_LOOP_A: rd_value = reg_loop_a;
			ADDR_LOOP_B: rd_value = reg_loop_b;
			ADDR_TUNE_A: rd_value = reg_tune_a;
			ADDR_TUNE_B: rd_value = reg_tune_b;
			ADDR_OUT_EN: rd_value = reg_out_en;
			default:     rd_value = RST_REG;
		endcase
	end

	// A frame is abandoned whenever select rises, so a short frame writes nothing.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state     <= PLC_IDLE;
			bit_cnt   <= 4'h0;
			shift_in  <= '0;
			wr_strobe <= 1'b0;
			wr_addr   <= '0;
			wr_data   <= '0;
		end
		else
		begin
			wr_strobe <= 1'b0;
			unique case (state)
				PLC_IDLE:
				begin
					bit_cnt <= 4'h0;
					if (!sel_n_s)
						state <= PLC_XFER;
				end
				PLC_XFER:
				begin
					if (sel_n_s)
						state <= PLC_IDLE;
					else if (sclk_rise && bit_cnt <= FRAME_LAST)
					begin
						shift_in <= {shift_in[FRAME_BITS-3:0], sdi_s};
						bit_cnt  <= bit_cnt + 4'h1;
						if (bit_cnt == FRAME_LAST && !shift_in[FRAME_BITS-2])
						begin
							wr_strobe <= 1'b1;
							wr_addr   <= shift_in[7:4];
							wr_data   <= {shift_in[3:0], sdi_s};
						end
					end
				end
			endcase
		end
	end

	// Read data leave on falling edges so the host samples them on rising ones.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rd_active   <= 1'b0;
			rd_shift    <= '0;
			port_sdo    <= 1'b0;
			port_sdo_oe <= 1'b0;
		end
		else if (state != PLC_XFER || sel_n_s)
		begin
			rd_active   <= 1'b0;
			port_sdo_oe <= 1'b0;
		end
		else if (sclk_rise && bit_cnt == HEADER_LAST)
		begin
			rd_active <= shift_in[3];
			rd_shift  <= rd_value;
		end
		else if (sclk_fall && rd_active)
		begin
			port_sdo    <= rd_shift[REG_W-1];
			port_sdo_oe <= 1'b1;
			rd_shift    <= {rd_shift[REG_W-2:0], 1'b0};
		end
	end

	// ****************************************************************
	// Command registers
	// ****************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			reg_loop_a <= RST_REG;
			reg_loop_b <= RST_REG;
			reg_tune_a <= RST_REG;
			reg_tune_b <= RST_REG;
			reg_out_en <= RST_REG;
		end
		else if (wr_strobe)
		begin
			unique case (wr_addr)
				ADDR_LOOP_A: reg_loop_a <= wr_data;
				ADDR_LOOP_B: reg_loop_b <= wr_data;
				// Tuning values are kept for read-back only.
				ADDR_TUNE_A: reg_tune_a <= wr_data;
				ADDR_TUNE_B: reg_tune_b <= wr_data;
				ADDR_OUT_EN: reg_out_en <= wr_data;
				default:     ;
			endcase
		end
	end

	// ****************************************************************
	// Output gating and lock indicator
	// ****************************************************************
	logic       a_en;
	logic       b_en;
	logic [1:0] lock_sel;
	logic       next_lock;

	assign a_en     = reg_loop_a[LOOP_EN_BIT];
	assign b_en     = reg_loop_b[LOOP_EN_BIT];
	assign lock_sel = {reg_out_en[LOCK_SEL1_BIT], reg_out_en[LOCK_SEL0_BIT]};

	always_comb
	begin
		unique case (lock_sel)
			// A disabled loop is treated as locked; no enabled loop means no lock.
			LOCK_BOTH:   next_lock = (a_en | b_en) & (~a_en | lock_a_s)
				& (~b_en | lock_b_s);
			LOCK_FIRST:  next_lock = lock_a_s;
			LOCK_SECOND: next_lock = lock_b_s;
			default:     next_lock = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			first_loop_run         <= 1'b0;
			second_loop_run        <= 1'b0;
			mode_field             <= '0;
			loop_multiplier        <= '0;
			frame_pulse_out_enable <= 1'b0;
			synth_out_a_gate       <= 1'b0;
			synth_out_b_gate       <= 1'b0;
			lock_indicator_out     <= 1'b0;
		end
		else
		begin
			first_loop_run         <= a_en;
			second_loop_run        <= b_en;
			mode_field             <= reg_loop_a[REG_W-1:FIELD_LSB];
			loop_multiplier        <= reg_loop_b[REG_W-1:FIELD_LSB];
			frame_pulse_out_enable <= reg_out_en[SYNC_EN_BIT];
			synth_out_a_gate       <= a_en & reg_out_en[OUT_A_EN_BIT];
			synth_out_b_gate       <= b_en & reg_out_en[OUT_B_EN_BIT];
			lock_indicator_out     <= next_lock;
		end
	end

endmodule

`default_nettype wire

//--- rtl/plc_pkg.sv
/*
 * Shared constants of the clock-synthesizer control block: register map,
 * field positions, reset values and the serial frame layout.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package plc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          REG_W          = 5;
	localparam int          ADDR_W         = 4;
	localparam logic [3:0]  ADDR_LOOP_A    = 4'h0;
	localparam logic [3:0]  ADDR_LOOP_B    = 4'h1;
	localparam logic [3:0]  ADDR_TUNE_A    = 4'h2;
	localparam logic [3:0]  ADDR_TUNE_B    = 4'h3;
	localparam logic [3:0]  ADDR_OUT_EN    = 4'h4;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int          LOOP_EN_BIT    = 0;
	localparam int          FIELD_LSB      = 1;
	localparam int          SYNC_EN_BIT    = 4;
	localparam int          OUT_A_EN_BIT   = 3;
	localparam int          OUT_B_EN_BIT   = 2;
	localparam int          LOCK_SEL1_BIT  = 1;
	localparam int          LOCK_SEL0_BIT  = 0;

	// Lock-detect selections, written as {bit1, bit0}.
	localparam logic [1:0]  LOCK_FORCE_LOW = 2'h0;
	localparam logic [1:0]  LOCK_SECOND    = 2'h1;
	localparam logic [1:0]  LOCK_FIRST     = 2'h2;
	localparam logic [1:0]  LOCK_BOTH      = 2'h3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [4:0]  RST_REG        = 5'h00;

	// ****************************************************************
	// Serial frame: read flag, address, then data, all MSB first
	// ****************************************************************
	localparam int          HEADER_BITS    = 1 + ADDR_W;
	localparam int          FRAME_BITS     = HEADER_BITS + REG_W;
	localparam logic [3:0]  HEADER_LAST    = 4'h4;
	localparam logic [3:0]  FRAME_LAST     = 4'h9;

	typedef enum logic [1:0]
	{
		PLC_IDLE = 2'b01,
		PLC_XFER = 2'b10
	} plc_state_t;

endpackage

`default_nettype wire

//--- rtl/plc_sync.sv
/*
 * Two-flop synchroniser for a bundle of independent level inputs.
 * Assumes every bit is a slow level or a clock far below clk_sys.
 */
`default_nettype none

module plc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second; nothing else looks at it.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			meta     <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire
